// ===== common/ufb_params.svh
// Purpose: Constants for the serial flow-control bridge
// Assumes: 200 MHz system clock
// Notes:   Bit times are clock cycles per serial bit
`ifndef UFB_PARAMS_SVH
`define UFB_PARAMS_SVH

`define UFB_CLK_HZ        200000000
`define UFB_BAUD_DEF      115200
`define UFB_BAUD_MIN      9600
`define UFB_BAUD_MAX      921600
// Power-up bit time, and the legal range of bit times
`define UFB_DIV_DEF       (`UFB_CLK_HZ / `UFB_BAUD_DEF)
`define UFB_DIV_MAX       (`UFB_CLK_HZ / `UFB_BAUD_MIN)
`define UFB_DIV_MIN       ((`UFB_CLK_HZ + `UFB_BAUD_MAX - 1) / `UFB_BAUD_MAX)
`define UFB_DIV_W         16
`define UFB_DATA_BITS     8
`define UFB_FIFO_DEPTH    16

`define UFB_REG_CTRL      8'h00
`define UFB_REG_BAUD      8'h04
`define UFB_REG_STAT      8'h08
`define UFB_REG_LEVEL     8'h0C

`define UFB_CTRL_MODE_LSB 0
`define UFB_MODE_RST      2'h0
`define UFB_MODE_RXTHR    0
`define UFB_MODE_TXGATE   1
`define UFB_STAT_RX_EMPTY 0
`define UFB_STAT_RX_FULL  1
`define UFB_STAT_TX_EMPTY 2
`define UFB_STAT_TX_FULL  3
`define UFB_STAT_RTS      4
`define UFB_STAT_EN       5
`define UFB_STAT_SOCK     6
`define UFB_STAT_TX_BUSY  7
`define UFB_STAT_FERR     8
`define UFB_STAT_OVR      9
`define UFB_LEVEL_RX_LSB  0
`define UFB_LEVEL_TX_LSB  8

`endif

// ===== common/ufb_pkg.sv
// Purpose: Types for the serial flow-control bridge
// Assumes: ufb_params.svh on the include path
// Notes:   State codes are one-hot
`include "ufb_params.svh"

package ufb_pkg;

  typedef enum logic [1:0]
  {
    UFB_HS_OFF  = 2'h0,
    UFB_HS_RTS  = 2'h1,
    UFB_HS_CTS  = 2'h2,
    UFB_HS_BOTH = 2'h3
  } ufb_hs_e;

  typedef enum logic [3:0]
  {
    UFB_S_IDLE  = 4'h1,
    UFB_S_START = 4'h2,
    UFB_S_DATA  = 4'h4,
    UFB_S_STOP  = 4'h8
  } ufb_ser_e;

  typedef struct packed
  {
    logic                        valid;
    logic [`UFB_DATA_BITS-1:0]   data;
  } ufb_byte_s;

  typedef struct packed
  {
    ufb_hs_e                     mode;
    logic [`UFB_DIV_W-1:0]       div;
  } ufb_cfg_s;

endpackage

// ===== hw/ufb_bridge.sv
// Purpose: Serial bridge between a target UART and two host byte paths
// Assumes: Host streams and register port on CLK; serial pins asynchronous
// Notes:   Flow-control pins are active low; socket path has priority
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ufb_params.svh"

module ufb_bridge
  import ufb_pkg::*;
#(
  parameter int DEPTH   = `UFB_FIFO_DEPTH,
  parameter int DIV_DEF = `UFB_DIV_DEF,
  parameter int DIV_MIN = `UFB_DIV_MIN,
  parameter int DIV_MAX = `UFB_DIV_MAX
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [31:0]      REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [31:0]      REG_RDATA,
  input  wire logic             SER_ENABLE,
  input  wire logic             SER_RXD,
  output logic                  SER_TXD,
  input  wire logic             TGT_RTS_N,
  output logic                  TGT_CTS_N_O,
  output logic                  TGT_CTS_N_OE,
  input  wire logic             SOCK_CONNECTED,
  input  wire ufb_pkg::ufb_byte_s USB_IN,
  output logic                  USB_IN_READY,
  input  wire ufb_pkg::ufb_byte_s SOCK_IN,
  output logic                  SOCK_IN_READY,
  output ufb_pkg::ufb_byte_s    USB_OUT,
  input  wire logic             USB_OUT_READY,
  output ufb_pkg::ufb_byte_s    SOCK_OUT,
  input  wire logic             SOCK_OUT_READY
);

  import ufb_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam int DW = `UFB_DATA_BITS;

  logic             en_s;
  logic             rxd_s;
  logic             rts_n_s;
  ufb_cfg_s         cfg;
  ufb_cfg_s         next_cfg;
  logic             ferr;
  logic             ovr;
  logic             next_ferr;
  logic             next_ovr;
  logic [31:0]      next_rdata;

  ufb_ser_e         rx_state;
  ufb_ser_e         next_rx_state;
  logic [15:0]      rx_cnt;
  logic [15:0]      next_rx_cnt;
  logic [2:0]       rx_bit;
  logic [2:0]       next_rx_bit;
  logic [DW-1:0]    rx_sh;
  logic [DW-1:0]    next_rx_sh;
  logic             rx_push;
  logic             rx_bad;
  logic             rx_in_ready;
  logic             rx_out_valid;
  logic             rx_out_ready;
  logic [DW-1:0]    rx_out_data;
  logic [CW-1:0]    rx_count;

  ufb_ser_e         tx_state;
  ufb_ser_e         next_tx_state;
  logic [15:0]      tx_cnt;
  logic [15:0]      next_tx_cnt;
  logic [2:0]       tx_bit;
  logic [2:0]       next_tx_bit;
  logic [DW-1:0]    tx_sh;
  logic [DW-1:0]    next_tx_sh;
  logic             next_txd;
  logic             tx_pop;
  logic             tx_clear;
  logic             tx_out_valid;
  logic [DW-1:0]    tx_out_data;
  logic             tx_in_ready;
  logic [CW-1:0]    tx_count;

  logic             next_cts_n;
  logic             next_cts_oe;
  logic             acc_usb;
  logic             acc_sock;
  logic             tx_push;
  logic [DW-1:0]    tx_push_data;
  logic             next_usb_rdy;
  logic             next_sock_rdy;
  logic             usb_v;
  logic             sock_v;
  logic [DW-1:0]    out_data;
  logic             next_usb_v;
  logic             next_sock_v;
  logic [DW-1:0]    next_out_data;
  logic             consumed;

  // Target RXD idles high, RTS_N idles deasserted
  ufb_sync #(.WIDTH(3), .RST_VAL(3'b110)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   ({SER_RXD, TGT_RTS_N, SER_ENABLE}),
    .dout  ({rxd_s, rts_n_s, en_s})
  );

  // Target-to-host buffer; its full flag throttles the target
  ufb_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_sh),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out_data),
    .count     (rx_count)
  );

  ufb_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_tx_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (tx_push_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data),
    .count     (tx_count)
  );

  // Receiver: start qualified at mid-bit, then one sample per bit time
  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_cnt   = (rx_cnt == '0) ? '0 : 16'(rx_cnt - 1'b1);
    next_rx_bit   = rx_bit;
    next_rx_sh    = rx_sh;
    rx_push       = 1'b0;
    rx_bad        = 1'b0;
    case (rx_state)
      UFB_S_IDLE:
      begin
        if (en_s && !rxd_s)
        begin
          next_rx_state = UFB_S_START;
          next_rx_cnt   = cfg.div >> 1;
        end
      end
      UFB_S_START:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_state = rxd_s ? UFB_S_IDLE : UFB_S_DATA;            // Glitch rejection
          next_rx_cnt   = 16'(cfg.div - 1'b1);
          next_rx_bit   = '0;
        end
      end
      UFB_S_DATA:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_sh  = {rxd_s, rx_sh[DW-1:1]};
          next_rx_cnt = 16'(cfg.div - 1'b1);
          next_rx_bit = 3'(rx_bit + 1'b1);
          if (rx_bit == 3'(DW - 1))
            next_rx_state = UFB_S_STOP;
        end
      end
      UFB_S_STOP:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_state = UFB_S_IDLE;
          rx_push       = rxd_s;
          rx_bad        = !rxd_s;
        end
      end
      default:
        next_rx_state = UFB_S_IDLE;
    endcase
  end

  // Transmitter: gating is checked only before a start bit
  assign tx_clear = !cfg.mode[`UFB_MODE_TXGATE] || !rts_n_s;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_cnt   = (tx_cnt == '0) ? '0 : 16'(tx_cnt - 1'b1);
    next_tx_bit   = tx_bit;
    next_tx_sh    = tx_sh;
    next_txd      = SER_TXD;
    tx_pop        = 1'b0;
    case (tx_state)
      UFB_S_IDLE:
      begin
        next_txd = 1'b1;
        if (en_s && tx_out_valid && tx_clear)
        begin
          tx_pop        = 1'b1;
          next_tx_sh    = tx_out_data;
          next_tx_state = UFB_S_START;
          next_tx_cnt   = 16'(cfg.div - 1'b1);
          next_txd      = 1'b0;
        end
      end
      UFB_S_START:
      begin
        if (tx_cnt == '0)
        begin
          next_tx_state = UFB_S_DATA;
          next_tx_cnt   = 16'(cfg.div - 1'b1);
          next_tx_bit   = '0;
          next_txd      = tx_sh[0];
        end
      end
      UFB_S_DATA:
      begin
        if (tx_cnt == '0)
        begin
          next_tx_cnt = 16'(cfg.div - 1'b1);
          next_tx_bit = 3'(tx_bit + 1'b1);
          next_tx_sh  = tx_sh >> 1;
          if (tx_bit == 3'(DW - 1))
          begin
            next_tx_state = UFB_S_STOP;
            next_txd      = 1'b1;
          end
          else
            next_txd = tx_sh[1];
        end
      end
      UFB_S_STOP:
      begin
        // Byte runs to its stop bit even if RTS drops meanwhile
        if (tx_cnt == '0)
          next_tx_state = UFB_S_IDLE;
      end
      default:
        next_tx_state = UFB_S_IDLE;
    endcase
  end

  // Flow pin toward the target and host-side steering
  always_comb
  begin
    next_cts_oe   = cfg.mode[`UFB_MODE_RXTHR];
    next_cts_n    = !rx_in_ready;
    acc_usb       = USB_IN.valid && USB_IN_READY;
    acc_sock      = SOCK_IN.valid && SOCK_IN_READY;
    tx_push       = acc_usb || acc_sock;
    tx_push_data  = acc_sock ? SOCK_IN.data : USB_IN.data;
    // Registered ready: only promise room that the next cycle surely has
    next_usb_rdy  = (CW'(tx_count + CW'(tx_push)) < CW'(DEPTH)) && !SOCK_CONNECTED;
    next_sock_rdy = (CW'(tx_count + CW'(tx_push)) < CW'(DEPTH)) && SOCK_CONNECTED;
    consumed      = (usb_v && USB_OUT_READY) || (sock_v && SOCK_OUT_READY);
    rx_out_ready  = (!usb_v && !sock_v) || consumed;
    next_usb_v    = usb_v && !consumed && !SOCK_CONNECTED;
    next_sock_v   = (sock_v || (usb_v && SOCK_CONNECTED)) && !consumed;
    next_out_data = out_data;
    if (rx_out_ready && rx_out_valid)
    begin
      next_usb_v    = !SOCK_CONNECTED;
      next_sock_v   = SOCK_CONNECTED;
      next_out_data = rx_out_data;
    end
  end

  // Register port: writes steer config, reads show live state
  always_comb
  begin
    next_cfg   = cfg;
    next_ferr  = ferr || rx_bad;
    next_ovr   = ovr || (rx_push && !rx_in_ready);
    next_rdata = '0;
    if (REG_WR)
    begin
      case (REG_ADDR)
        `UFB_REG_CTRL:
          next_cfg.mode = ufb_hs_e'(REG_WDATA[`UFB_CTRL_MODE_LSB +: 2]);
        `UFB_REG_BAUD:
        begin
          if (REG_WDATA[15:0] < 16'(DIV_MIN))
            next_cfg.div = 16'(DIV_MIN);
          else if (REG_WDATA[15:0] > 16'(DIV_MAX))
            next_cfg.div = 16'(DIV_MAX);
          else
            next_cfg.div = REG_WDATA[15:0];
        end
        `UFB_REG_STAT:
        begin
          // Write one to clear; a same-cycle event still sets
          next_ferr = (ferr && !REG_WDATA[`UFB_STAT_FERR]) || rx_bad;
          next_ovr  = (ovr && !REG_WDATA[`UFB_STAT_OVR]) || (rx_push && !rx_in_ready);
        end
        default:
          next_cfg = cfg;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        `UFB_REG_CTRL:
          next_rdata[`UFB_CTRL_MODE_LSB +: 2] = cfg.mode;
        `UFB_REG_BAUD:
          next_rdata[15:0] = cfg.div;
        `UFB_REG_STAT:
        begin
          next_rdata[`UFB_STAT_RX_EMPTY] = !rx_out_valid;
          next_rdata[`UFB_STAT_RX_FULL]  = !rx_in_ready;
          next_rdata[`UFB_STAT_TX_EMPTY] = !tx_out_valid;
          next_rdata[`UFB_STAT_TX_FULL]  = !tx_in_ready;
          next_rdata[`UFB_STAT_RTS]      = !rts_n_s;
          next_rdata[`UFB_STAT_EN]       = en_s;
          next_rdata[`UFB_STAT_SOCK]     = SOCK_CONNECTED;
          next_rdata[`UFB_STAT_TX_BUSY]  = (tx_state != UFB_S_IDLE);
          next_rdata[`UFB_STAT_FERR]     = ferr;
          next_rdata[`UFB_STAT_OVR]      = ovr;
        end
        `UFB_REG_LEVEL:
        begin
          next_rdata[`UFB_LEVEL_RX_LSB +: CW] = rx_count;
          next_rdata[`UFB_LEVEL_TX_LSB +: CW] = tx_count;
        end
        default:
          next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cfg.mode      <= UFB_HS_OFF;
      cfg.div       <= 16'(DIV_DEF);
      ferr          <= 1'b0;
      ovr           <= 1'b0;
      REG_RDATA     <= '0;
      rx_state      <= UFB_S_IDLE;
      rx_cnt        <= '0;
      rx_bit        <= '0;
      rx_sh         <= '0;
      tx_state      <= UFB_S_IDLE;
      tx_cnt        <= '0;
      tx_bit        <= '0;
      tx_sh         <= '0;
      SER_TXD       <= 1'b1;
      TGT_CTS_N_O   <= 1'b1;
      TGT_CTS_N_OE  <= 1'b0;
      USB_IN_READY  <= 1'b0;
      SOCK_IN_READY <= 1'b0;
      usb_v         <= 1'b0;
      sock_v        <= 1'b0;
      out_data      <= '0;
    end
    else
    begin
      cfg           <= next_cfg;
      ferr          <= next_ferr;
      ovr           <= next_ovr;
      REG_RDATA     <= next_rdata;
      rx_state      <= next_rx_state;
      rx_cnt        <= next_rx_cnt;
      rx_bit        <= next_rx_bit;
      rx_sh         <= next_rx_sh;
      tx_state      <= next_tx_state;
      tx_cnt        <= next_tx_cnt;
      tx_bit        <= next_tx_bit;
      tx_sh         <= next_tx_sh;
      SER_TXD       <= next_txd;
      TGT_CTS_N_O   <= next_cts_n;
      TGT_CTS_N_OE  <= next_cts_oe;
      USB_IN_READY  <= next_usb_rdy;
      SOCK_IN_READY <= next_sock_rdy;
      usb_v         <= next_usb_v;
      sock_v        <= next_sock_v;
      out_data      <= next_out_data;
    end
  end

  assign USB_OUT  = '{valid: usb_v, data: out_data};
  assign SOCK_OUT = '{valid: sock_v, data: out_data};

endmodule // ufb_bridge

// ===== hw/ufb_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Count is exact; full and empty come from it
`timescale 1ns/1ps

module ufb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH),
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CW-1:0]    count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
    if (pop)
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
    if (push && !pop)
      next_count = CW'(count + 1'b1);
    else if (pop && !push)
      next_count = CW'(count - 1'b1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; only written slots are ever read
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule // ufb_fifo

// ===== hw/ufb_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module ufb_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // ufb_sync

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the serial bridge
// Assumes: Shortened bit times; pull-up on clear-to-send
// Notes:   Random bytes from a fixed seed
`timescale 1ns/1ps
`include "ufb_params.svh"

module testbench;
  import ufb_pkg::*;
  localparam int DMIN = 4;
  localparam int DMAX = 64;
  localparam int DDEF = 16;
  localparam int B    = 8;
  logic        clk, rst_n, reg_wr, reg_rd, ser_enable, ser_rxd, ser_txd;
  logic        tgt_rts_n, cts_o, cts_oe, sock_connected, use_cts, rts_hold;
  logic        usb_in_ready, sock_in_ready, usb_out_ready, sock_out_ready;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  ufb_byte_s   usb_in, sock_in, usb_out, sock_out;
  logic [7:0]  exp_q[$], usb_q[$], sock_q[$];
  int          fail_count = 0;
  int          checks_done = 0;

  ufb_bridge #(.DEPTH(16), .DIV_DEF(DDEF), .DIV_MIN(DMIN), .DIV_MAX(DMAX)) DUT (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SER_ENABLE(ser_enable), .SER_RXD(ser_rxd),
    .SER_TXD(ser_txd), .TGT_RTS_N(tgt_rts_n), .TGT_CTS_N_O(cts_o), .TGT_CTS_N_OE(cts_oe),
    .SOCK_CONNECTED(sock_connected), .USB_IN(usb_in), .USB_IN_READY(usb_in_ready),
    .SOCK_IN(sock_in), .SOCK_IN_READY(sock_in_ready), .USB_OUT(usb_out),
    .USB_OUT_READY(usb_out_ready), .SOCK_OUT(sock_out), .SOCK_OUT_READY(sock_out_ready));

  ufb_target_model u_tgt (.clk(clk), .bit_cyc(16'(B)), .use_cts(use_cts),
    .rts_hold(rts_hold), .txd(ser_txd), .cts_n(cts_oe ? cts_o : 1'b1), .rxd(ser_rxd),
    .rts_n(tgt_rts_n));

  always @(posedge clk)
  begin
    if (usb_out.valid && usb_out_ready) usb_q.push_back(usb_out.data);
    if (sock_out.valid && sock_out_ready) sock_q.push_back(sock_out.data);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_q(ref logic [7:0] q[$]);
    check(q.size(), exp_q.size());
    while (q.size() > 0 && exp_q.size() > 0)
      check(q.pop_front(), exp_q.pop_front());
    exp_q.delete();
  endtask

  task automatic wait_q(ref logic [7:0] q[$], input int n);
    for (int k = 0; k < 5000 && q.size() < n; k++) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic send_burst(input logic sock, input int n);
    logic [7:0] b;
    repeat (n)
    begin
      b = 8'($urandom_range(0, 255));
      exp_q.push_back(b);
      @(posedge clk);
      if (sock) sock_in <= {1'b1, b};
      else usb_in <= {1'b1, b};
      for (int k = 0; k < 5000; k++)
      begin
        @(negedge clk);
        if ((sock ? sock_in_ready : usb_in_ready) === 1'b1) break;
      end
      @(posedge clk);
      sock_in.valid <= 1'b0;
      usb_in.valid  <= 1'b0;
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, sock_connected} = '0;
    {ser_enable, rts_hold, usb_out_ready, sock_out_ready, use_cts} = 5'b11110;
    usb_in  = '0;
    sock_in = '0;
    void'($urandom(55601));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`UFB_REG_CTRL); check(d, 32'h0);
    rd(`UFB_REG_BAUD); check(d, DDEF);
    rd(8'h10); check(d, 32'h0);
    rd(`UFB_REG_STAT); check(d, 32'h0000_0025);
    check(cts_oe, 1'b0);
    wr(`UFB_REG_BAUD, 32'h0000_0002); rd(`UFB_REG_BAUD); check(d, DMIN);
    wr(`UFB_REG_BAUD, 32'h0000_00C8); rd(`UFB_REG_BAUD); check(d, DMAX);
    wr(`UFB_REG_BAUD, B);
    for (int m = 3; m >= 0; m--)
    begin
      wr(`UFB_REG_CTRL, m);
      repeat (3) @(posedge clk);
      check(cts_oe, m[0]);
      rd(`UFB_REG_CTRL); check(d[1:0], m[1:0]);
    end
    // Gating off: hold-off ignored
    send_burst(0, 4); wait_q(u_tgt.rx_q, 4); cmp_q(u_tgt.rx_q);
    wr(`UFB_REG_CTRL, UFB_HS_CTS);
    send_burst(0, 2); repeat (300) @(posedge clk);
    check(u_tgt.rx_q.size(), 0);
    rts_hold <= 1'b0;
    wait_q(u_tgt.rx_q, 2); cmp_q(u_tgt.rx_q);
    // Hold-off mid-frame: that frame completes
    send_burst(0, 3);
    for (int k = 0; k < 500 && ser_txd !== 1'b0; k++) @(posedge clk);
    rts_hold <= 1'b1;
    repeat (300) @(posedge clk);
    check(u_tgt.rx_q.size(), 1);
    rts_hold <= 1'b0;
    wait_q(u_tgt.rx_q, 3); cmp_q(u_tgt.rx_q);
    // Host stalls; buffer fills
    wr(`UFB_REG_CTRL, UFB_HS_BOTH);
    use_cts       <= 1'b1;
    usb_out_ready <= 1'b0;
    fork
      for (int i = 0; i < 20; i++)
      begin
        logic [7:0] b;
        b = 8'($urandom_range(0, 255));
        exp_q.push_back(b);
        u_tgt.send_byte(b);
      end
    join_none
    for (int k = 0; k < 5000 && cts_o !== 1'b1; k++) @(posedge clk);
    repeat (300) @(posedge clk);
    check(cts_o, 1'b1);
    check(u_tgt.sent < 20, 1'b1);
    usb_out_ready <= 1'b1;
    wait_q(usb_q, 20); cmp_q(usb_q);
    // Socket takes the host side
    sock_connected <= 1'b1;
    repeat (3) @(posedge clk);
    check(usb_in_ready, 1'b0);
    send_burst(1, 2); wait_q(u_tgt.rx_q, 2); cmp_q(u_tgt.rx_q);
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back(8'(8'hA5 ^ i));
      u_tgt.send_byte(8'(8'hA5 ^ i));
    end
    wait_q(sock_q, 2); cmp_q(sock_q);
    check(usb_q.size(), 0);
    sock_connected <= 1'b0;
    ser_enable     <= 1'b0;
    send_burst(0, 1); repeat (300) @(posedge clk);
    check(u_tgt.rx_q.size(), 0);
    ser_enable <= 1'b1;
    wait_q(u_tgt.rx_q, 1); cmp_q(u_tgt.rx_q);
    finish_test();
  end
endmodule // testbench

// ===== tb/ufb_bridge_props.sv
// Purpose: Concurrent checks on the serial bridge ports
// Assumes: Bit time never changes while a frame is on the wire
// Notes:   Mode and bit time are shadowed from register writes
`timescale 1ns/1ps
`include "ufb_params.svh"

module ufb_bridge_props
  import ufb_pkg::*;
#(
  parameter int DEPTH   = 16,
  parameter int DIV_DEF = 1736,
  parameter int DIV_MIN = 217,
  parameter int DIV_MAX = 20833
) (
  input wire logic                CLK,
  input wire logic                RST_N,
  input wire logic [7:0]          REG_ADDR,
  input wire logic [31:0]         REG_WDATA,
  input wire logic                REG_WR,
  input wire logic                REG_RD,
  input wire logic [31:0]         REG_RDATA,
  input wire logic                SER_ENABLE,
  input wire logic                SER_TXD,
  input wire logic                TGT_RTS_N,
  input wire logic                TGT_CTS_N_OE,
  input wire logic                SOCK_CONNECTED,
  input wire logic                USB_IN_READY,
  input wire logic                SOCK_IN_READY,
  input wire ufb_pkg::ufb_byte_s  USB_OUT,
  input wire logic                USB_OUT_READY
);
  logic [1:0]  hs_mode;
  logic [1:0]  next_hs_mode;
  logic [15:0] baud;
  logic [15:0] next_baud;
  logic [19:0] tx_cnt;
  logic [19:0] next_tx_cnt;
  logic [3:0]  rts_hi;
  logic [3:0]  next_rts_hi;
  logic [3:0]  en_lo;
  logic [3:0]  next_en_lo;
  logic        txd_q;
  logic        tx_fall;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  always_comb
  begin
    next_hs_mode = hs_mode;
    next_baud    = baud;
    if (REG_WR && REG_ADDR == `UFB_REG_CTRL)
      next_hs_mode = REG_WDATA[1:0];
    if (REG_WR && REG_ADDR == `UFB_REG_BAUD)
      next_baud = (REG_WDATA[15:0] < DIV_MIN) ? 16'(DIV_MIN) :
                  (REG_WDATA[15:0] > DIV_MAX) ? 16'(DIV_MAX) : REG_WDATA[15:0];
    tx_fall     = txd_q && !SER_TXD;
    // Ten bit times from the start edge
    next_tx_cnt = (tx_cnt != 20'h0) ? tx_cnt - 20'h1 :
                  (tx_fall ? 20'(baud) * 20'd10 - 20'h1 : 20'h0);
    next_rts_hi = !TGT_RTS_N ? 4'h0 : (rts_hi == 4'hF ? rts_hi : rts_hi + 4'h1);
    next_en_lo  = SER_ENABLE ? 4'h0 : (en_lo == 4'hF ? en_lo : en_lo + 4'h1);
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      hs_mode <= 2'h0;
      baud    <= 16'(DIV_DEF);
      tx_cnt  <= 20'h0;
      rts_hi  <= 4'h0;
      en_lo   <= 4'h0;
      txd_q   <= 1'b1;
    end
    else
    begin
      hs_mode <= next_hs_mode;
      baud    <= next_baud;
      tx_cnt  <= next_tx_cnt;
      rts_hi  <= next_rts_hi;
      en_lo   <= next_en_lo;
      txd_q   <= SER_TXD;
    end
  end

  sequence s_tx_start;
    tx_cnt == 20'h0 && tx_fall;
  endsequence

  chk_reset_idle: assert property (disable iff (1'b0)
    !RST_N |=> SER_TXD && !TGT_CTS_N_OE && REG_RDATA == 32'h0 && !USB_OUT.valid)
    else $error("outputs not idle in reset");
  chk_baud_read: assert property (
    REG_RD && REG_ADDR == `UFB_REG_BAUD |=> REG_RDATA[15:0] == baud)
    else $error("bit time readback wrong");
  chk_cts_enable: assert property ($stable(hs_mode) |-> TGT_CTS_N_OE == hs_mode[0])
    else $error("clear-to-send enable does not follow mode");
  chk_tx_gate: assert property (s_tx_start |-> !(hs_mode[1] && rts_hi >= 4'd6))
    else $error("frame started while target holds off");
  chk_tx_enable: assert property (s_tx_start |-> en_lo < 4'd6)
    else $error("frame started while disabled");
  chk_start_low: assert property (tx_cnt > 20'(baud) * 20'd9 |-> !SER_TXD)
    else $error("start bit not low for a bit time");
  chk_stop_high: assert property (
    tx_cnt != 20'h0 && tx_cnt <= 20'(baud) |-> SER_TXD)
    else $error("stop bit not high or frame cut");
  chk_usb_shut: assert property (SOCK_CONNECTED |=> !USB_IN_READY && !USB_OUT.valid)
    else $error("usb input open while socket connected");
  chk_sock_shut: assert property (!SOCK_CONNECTED |=> !SOCK_IN_READY)
    else $error("socket input open while unconnected");
  chk_out_hold: assert property (
    USB_OUT.valid && !USB_OUT_READY && !SOCK_CONNECTED |=> USB_OUT.valid && $stable(USB_OUT.data))
    else $error("usb output byte lost");
endmodule // ufb_bridge_props

bind ufb_bridge ufb_bridge_props #(.DEPTH(DEPTH), .DIV_DEF(DIV_DEF), .DIV_MIN(DIV_MIN),
  .DIV_MAX(DIV_MAX)) u_props (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .SER_ENABLE(SER_ENABLE), .SER_TXD(SER_TXD), .TGT_RTS_N(TGT_RTS_N),
  .TGT_CTS_N_OE(TGT_CTS_N_OE), .SOCK_CONNECTED(SOCK_CONNECTED), .USB_IN_READY(USB_IN_READY),
  .SOCK_IN_READY(SOCK_IN_READY), .USB_OUT(USB_OUT), .USB_OUT_READY(USB_OUT_READY));

// ===== tb/ufb_target_model.sv
// Purpose: Behavioural target UART with flow-control pins
// Assumes: Bit time given in clock cycles
// Notes:   Leaves one idle bit between frames
`timescale 1ns/1ps

module ufb_target_model (
  input  wire logic        clk,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        use_cts,
  input  wire logic        rts_hold,
  input  wire logic        txd,
  input  wire logic        cts_n,
  output logic             rxd,
  output logic             rts_n
);
  logic [7:0] rx_q[$];
  int         sent = 0;

  initial rxd = 1'b1;
  assign rts_n = rts_hold;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge clk);
    while (use_cts && cts_n !== 1'b0)
      @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= fr[i];
      repeat (bit_cyc) @(posedge clk);
    end
    repeat (bit_cyc) @(posedge clk);
    sent++;
  endtask

  always
  begin : receiver
    logic [7:0] b;
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_cyc) @(posedge clk);
      b[i] = txd;
    end
    repeat (bit_cyc) @(posedge clk);
    // Bad stop bit gives unknown
    rx_q.push_back(txd === 1'b1 ? b : 8'hxx);
  end
endmodule // ufb_target_model
